// file: rtl/acs_map.vh
// Register indices, field layout, reset values and timing counts of the
// accumulator source selection register bank.
// Assumes an includer that uses these as plain constants.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ACS_IDX_PENDING    8'h25
`define ACS_IDX_ACTIVE     8'h4a
`define ACS_IDX_LATCHED    8'h4b
`define ACS_IDX_COMMAND    8'h80
`define ACS_IDX_STATUS     8'h81
`define ACS_IDX_PRODUCT    8'hfd
`define ACS_IDX_MAKER      8'hfe
`define ACS_IDX_REVISION   8'hff

// ****************************************************************
// Field layout of the selection registers
// ****************************************************************
`define ACS_CH1_MSB        7
`define ACS_CH1_LSB        6
`define ACS_CH2_MSB        5
`define ACS_CH2_LSB        4
`define ACS_CH3_MSB        3
`define ACS_CH3_LSB        2
`define ACS_CH4_MSB        1
`define ACS_CH4_LSB        0

// Source codes
`define ACS_SRC_POWER      2'h0
`define ACS_SRC_SENSE      2'h1
`define ACS_SRC_BUS        2'h2
`define ACS_SRC_RESERVED   2'h3

// ****************************************************************
// Command and status bits
// ****************************************************************
`define ACS_CMD_REFRESH    0
`define ACS_CMD_REFRESH_V  1
`define ACS_CMD_REFRESH_G  2
`define ACS_STS_VALID      0

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define ACS_SEL_RESET      8'h00
`define ACS_RESULT_WAIT_MS 1
`define ACS_CLK_MHZ        100
// One result wait at ACS_CLK_MHZ, in clock cycles
`define ACS_RESULT_WAIT_CYC 17'd100000

`endif

// file: rtl/acs_sel_reg.v
// One 8-bit selection register of four 2-bit channel source fields.
// Assumes a load strobe from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_sel_reg (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       load,
  input  wire [7:0] d,
  output wire [7:0] q
);

  reg [7:0] sel_ff;

  // Reserved code folds to the power product
  function [1:0] clean_field;
    input [1:0] f;
    begin
      if (f == `ACS_SRC_RESERVED) begin
        clean_field = `ACS_SRC_POWER;
      end else begin
        clean_field = f;
      end
    end
  endfunction

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // R9: reset to power
      sel_ff <= `ACS_SEL_RESET;
    end else if (load) begin
      // R8: reserved reads zero
      sel_ff <= {clean_field(d[`ACS_CH1_MSB:`ACS_CH1_LSB]),
                 clean_field(d[`ACS_CH2_MSB:`ACS_CH2_LSB]),
                 clean_field(d[`ACS_CH3_MSB:`ACS_CH3_LSB]),
                 clean_field(d[`ACS_CH4_MSB:`ACS_CH4_LSB])};
    end
  end

  assign q = sel_ff;

endmodule // acs_sel_reg

`default_nettype wire

// file: rtl/acs_ahb_if.v
// AHB-Lite slave front end: address phase capture, write strobe, read data.
// Assumes one slave, single word transfers; reads take one wait state.
`timescale 1ns/1ps
`default_nettype none

module acs_ahb_if (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] rd_word,
  output wire        wr_stb,
  output wire        rd_stb,
  output wire [7:0]  reg_idx,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp
);

  reg        wr_ph_ff;
  reg        rd_ph_ff;
  reg [7:0]  idx_ff;
  reg [31:0] hrdata_ff;
  reg        hreadyout_ff;

  wire take    = hsel & htrans[1] & hready;
  wire aligned = (haddr[1:0] == 2'h0) && (hsize == 3'h2) && (haddr[31:10] == 22'h0);

  // ****************************************************************
  // Address phase capture
  // ****************************************************************
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ph_ff     <= 1'b0;
      rd_ph_ff     <= 1'b0;
      idx_ff       <= 8'h00;
      hrdata_ff    <= 32'h0;
      hreadyout_ff <= 1'b1;
    end else begin
      wr_ph_ff <= take & hwrite & aligned;
      if (take) begin
        idx_ff <= haddr[9:2];
      end
      if (take & ~hwrite) begin
        // Misaligned reads still complete, with zero data
        rd_ph_ff     <= 1'b1;
        hreadyout_ff <= 1'b0;
        if (!aligned) begin
          idx_ff <= 8'h00;
        end
      end else if (rd_ph_ff) begin
        rd_ph_ff     <= 1'b0;
        hrdata_ff    <= rd_word;
        hreadyout_ff <= 1'b1;
      end
    end
  end

  assign wr_stb    = wr_ph_ff;
  assign rd_stb    = rd_ph_ff;
  assign reg_idx   = idx_ff;
  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = 1'b0;

endmodule // acs_ahb_if

`default_nettype wire

// file: rtl/acs_top.v
// Accumulator source selection bank: pending, active and latched images,
// refresh commands, result-valid timer and identification registers.
// Assumes an AHB-Lite master on clk_sys with this as the only slave.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

// Contract
// R1: The active register at index 4Ah always shows the channel sources in force.
// R2: Writes to the pending register at 25h take effect only on a refresh command.
// R3: Any refresh variant makes the latched register at 4Bh take the pre-refresh active value.
// R4: The latched register matches the dataset held in the result registers.
// R5: Software trusts the latched register only 1 ms after a refresh, when results are valid.
// R6: Both images are 8 bits, channel 1 in bits 7-6 down to channel 4 in bits 1-0.
// R7: Field code 00 is power, 01 sense voltage, 10 bus voltage.
// R8: Field code 11 is reserved and reads as zero.
// R9: After reset every field of both images reads 0, power accumulation.
// R10: A read-only product code sits at index FDh.
// R11: A read-only maker code sits at index FEh.
// R12: A read-only die revision code sits at index FFh.
// R13: A refresh copies active to latched and pending to active in one clock.
module acs_top #(
  parameter [7:0]  PRODUCT_CODE        = 8'h3c,  // Arbitrary value
  parameter [7:0]  MAKER_CODE          = 8'h5a,  // Arbitrary value
  parameter [7:0]  DIE_REV_CODE        = 8'h01,  // Arbitrary value
  parameter        CNT_W               = 17,
  parameter [16:0] RESULT_WAIT_CYCLES  = `ACS_RESULT_WAIT_CYC
) (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [2:0]  hburst,
  input  wire [3:0]  hprot,
  input  wire        hmastlock,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output wire [1:0]  ch1_accum_source_sel,
  output wire [1:0]  ch2_accum_source_sel,
  output wire [1:0]  ch3_accum_source_sel,
  output wire [1:0]  ch4_accum_source_sel,
  output wire        refresh_strobe,
  output wire        results_valid
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire             wr_stb;
  wire             rd_stb;
  wire [7:0]       reg_idx;
  wire [7:0]       pending_q;
  wire [7:0]       active_q;
  wire [7:0]       latched_q;
  wire             pending_wr;
  wire             refresh_cmd;
  reg  [31:0]      rd_word;
  reg              refresh_strobe_ff;
  reg              results_valid_ff;
  reg  [CNT_W-1:0] wait_cnt_ff;
  reg  [CNT_W-1:0] nxt_wait_cnt;
  reg              nxt_results_valid;

  // Unused bus attributes: only single word transfers are served
  wire unused_attr = ^{hburst, hprot, hmastlock, rd_stb};

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  acs_ahb_if u_ahb (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rd_word   (rd_word),
    .wr_stb    (wr_stb),
    .rd_stb    (rd_stb),
    .reg_idx   (reg_idx),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************
  assign pending_wr  = wr_stb && (reg_idx == `ACS_IDX_PENDING);

  // R3: any refresh variant
  assign refresh_cmd = wr_stb && (reg_idx == `ACS_IDX_COMMAND) &&
                       (hwdata[`ACS_CMD_REFRESH]   |
                        hwdata[`ACS_CMD_REFRESH_V] |
                        hwdata[`ACS_CMD_REFRESH_G]);

  // ****************************************************************
  // Selection images
  // ****************************************************************
  // R2: pending held apart
  acs_sel_reg u_pending (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (pending_wr),
    .d       (hwdata[7:0]),
    .q       (pending_q)
  );

  // R13: pending to active on refresh
  acs_sel_reg u_active (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (refresh_cmd),
    .d       (pending_q),
    .q       (active_q)
  );

  // R13: active to latched same edge
  acs_sel_reg u_latched (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (refresh_cmd),
    .d       (active_q),
    .q       (latched_q)
  );

  // ****************************************************************
  // Refresh strobe and result-valid timer
  // ****************************************************************
  // R4: results follow latched image
  always @* begin
    nxt_wait_cnt      = wait_cnt_ff;
    nxt_results_valid = results_valid_ff;
    if (refresh_cmd) begin
      nxt_wait_cnt      = RESULT_WAIT_CYCLES[CNT_W-1:0];
      nxt_results_valid = 1'b0;
    end else if (wait_cnt_ff != {CNT_W{1'b0}}) begin
      nxt_wait_cnt = wait_cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
      if (wait_cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        // R5: valid after wait
        nxt_results_valid = 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      refresh_strobe_ff <= 1'b0;
      results_valid_ff  <= 1'b0;
      wait_cnt_ff       <= {CNT_W{1'b0}};
    end else begin
      refresh_strobe_ff <= refresh_cmd;
      results_valid_ff  <= nxt_results_valid;
      wait_cnt_ff       <= nxt_wait_cnt;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always @* begin
    rd_word = 32'h0;
    case (reg_idx)
      `ACS_IDX_PENDING: begin
        rd_word = {24'h0, pending_q};
      end
      // R1: active image readback
      `ACS_IDX_ACTIVE: begin
        rd_word = {24'h0, active_q};
      end
      // R6: latched image readback
      `ACS_IDX_LATCHED: begin
        rd_word = {24'h0, latched_q};
      end
      `ACS_IDX_STATUS: begin
        rd_word = {31'h0, results_valid_ff};
      end
      // R10: product code
      `ACS_IDX_PRODUCT: begin
        rd_word = {24'h0, PRODUCT_CODE};
      end
      // R11: maker code
      `ACS_IDX_MAKER: begin
        rd_word = {24'h0, MAKER_CODE};
      end
      // R12: die revision
      `ACS_IDX_REVISION: begin
        rd_word = {24'h0, DIE_REV_CODE};
      end
      default: begin
        rd_word = {31'h0, unused_attr & 1'b0};
      end
    endcase
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // R7: codes drive the accumulators
  assign ch1_accum_source_sel = active_q[`ACS_CH1_MSB:`ACS_CH1_LSB];
  assign ch2_accum_source_sel = active_q[`ACS_CH2_MSB:`ACS_CH2_LSB];
  assign ch3_accum_source_sel = active_q[`ACS_CH3_MSB:`ACS_CH3_LSB];
  assign ch4_accum_source_sel = active_q[`ACS_CH4_MSB:`ACS_CH4_LSB];
  assign refresh_strobe       = refresh_strobe_ff;
  assign results_valid        = results_valid_ff;

endmodule // acs_top

`default_nettype wire

// file: sim/acs_top_chk.sv
// Checker for the selection bank: bus timing, refresh effects, read values.
// Assumes it is bound to acs_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module acs_top_chk #(
  parameter [7:0] PRODUCT_CODE = 8'h3c,
  parameter [7:0] DIE_REV_CODE = 8'h01,
  parameter [16:0] RESULT_WAIT_CYCLES = `ACS_RESULT_WAIT_CYC
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [1:0]  ch1_accum_source_sel,
  input wire logic [1:0]  ch2_accum_source_sel,
  input wire logic [1:0]  ch3_accum_source_sel,
  input wire logic [1:0]  ch4_accum_source_sel,
  input wire logic        refresh_strobe,
  input wire logic        results_valid
);
  wire [7:0] sel_now;
  int unsigned wait_seen;
  // Cycles from the refresh pulse until results turn valid
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_seen <= 0;
    end else if (refresh_strobe) begin
      wait_seen <= 1;
    end else if (wait_seen != 0 && !results_valid) begin
      wait_seen <= wait_seen + 1;
    end
  end
  assign sel_now = {ch1_accum_source_sel, ch2_accum_source_sel,
                    ch3_accum_source_sel, ch4_accum_source_sel};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_at(logic [31:0] a);
    s_rd_take ##0 (haddr == a);
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_rd_wait;
    s_rd_take |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_active_rd;
    s_rd_at({22'h0, `ACS_IDX_ACTIVE, 2'b00}) |=> ##1 hrdata == {24'h0, sel_now};
  endproperty
  a_active_rd: assert property (p_active_rd) else $error("active read differs");
  property p_prod;
    s_rd_at({22'h0, `ACS_IDX_PRODUCT, 2'b00}) |=> ##1 hrdata == {24'h0, PRODUCT_CODE};
  endproperty
  a_prod: assert property (p_prod) else $error("product code wrong");
  property p_rev;
    s_rd_at({22'h0, `ACS_IDX_REVISION, 2'b00}) |=> ##1 hrdata == {24'h0, DIE_REV_CODE};
  endproperty
  a_rev: assert property (p_rev) else $error("revision code wrong");
  property p_hold;
    !$stable(sel_now) |-> refresh_strobe;
  endproperty
  a_hold: assert property (p_hold) else $error("sources changed without refresh");
  property p_rsvd;
    ch1_accum_source_sel != 2'h3 && ch2_accum_source_sel != 2'h3 &&
    ch3_accum_source_sel != 2'h3 && ch4_accum_source_sel != 2'h3;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved source code shown");
  property p_reset;
    $rose(resetn) |-> sel_now == 8'h00 && !results_valid;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_busy;
    refresh_strobe |-> !results_valid [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("results valid too early");
  property p_ready;
    refresh_strobe |-> ##[1:1000] results_valid;
  endproperty
  a_ready: assert property (p_ready) else $error("results never valid");
  property p_pulse;
    refresh_strobe |=> !refresh_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("refresh pulse too long");
  property p_valid_time;
    $rose(results_valid) |-> wait_seen == RESULT_WAIT_CYCLES;
  endproperty
  a_valid_time: assert property (p_valid_time) else $error("result wait length wrong");
endmodule // acs_top_chk
bind acs_top acs_top_chk #(.PRODUCT_CODE(PRODUCT_CODE), .DIE_REV_CODE(DIE_REV_CODE),
                           .RESULT_WAIT_CYCLES(RESULT_WAIT_CYCLES)) u_chk (.*);
`default_nettype wire

// file: sim/tb_accum_config_shadow_and_id_regs.sv
// Self-checking bench for the selection bank, driven over AHB-Lite.
// Assumes acs_top with its checker bound; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module tb_accum_config_shadow_and_id_regs;
  localparam [7:0]  PROD     = 8'h3c;  // Arbitrary value
  localparam [7:0]  MAKER    = 8'h5a;  // Arbitrary value
  localparam [7:0]  REV      = 8'h01;  // Arbitrary value
  localparam [16:0] WAIT_CYC = 17'd20;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [1:0]  ch1_sel;
  wire  [1:0]  ch2_sel;
  wire  [1:0]  ch3_sel;
  wire  [1:0]  ch4_sel;
  wire         refresh_strobe;
  wire         results_valid;
  int          err_total  = 0;
  int          num_checks = 0;
  int          i;
  int          k;
  logic [31:0] rd;
  logic [7:0]  prev;
  logic [7:0]  pend_val [3] = '{8'h1b, 8'he4, 8'h6c};
  logic [7:0]  pend_exp [3] = '{8'h18, 8'h24, 8'h60};

  always #5 clk_sys = ~clk_sys;

  acs_top #(.PRODUCT_CODE(PROD), .MAKER_CODE(MAKER), .DIE_REV_CODE(REV),
            .RESULT_WAIT_CYCLES(WAIT_CYC)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hburst(3'h0), .hprot(4'h0), .hmastlock(1'b0),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ch1_accum_source_sel(ch1_sel), .ch2_accum_source_sel(ch2_sel),
    .ch3_accum_source_sel(ch3_sel), .ch4_accum_source_sel(ch4_sel),
    .refresh_strobe(refresh_strobe), .results_valid(results_valid)
  );

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, idx, 2'b00};
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk({31'h0, hreadyout}, 32'h1);
    end
    rdata = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    xfer(1'b0, idx, 8'h00, v);
    chk(v, {24'h0, exp});
  endtask

  task automatic report_and_stop;
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd_chk(`ACS_IDX_ACTIVE, `ACS_SEL_RESET);
    rd_chk(`ACS_IDX_LATCHED, `ACS_SEL_RESET);
    chk({24'h0, ch1_sel, ch2_sel, ch3_sel, ch4_sel}, 32'h0);
    rd_chk(`ACS_IDX_PRODUCT, PROD);
    rd_chk(`ACS_IDX_MAKER, MAKER);
    rd_chk(`ACS_IDX_REVISION, REV);
    xfer(1'b1, `ACS_IDX_PRODUCT, 8'hff, rd);
    rd_chk(`ACS_IDX_PRODUCT, PROD);
    xfer(1'b1, `ACS_IDX_ACTIVE, 8'h55, rd);
    rd_chk(`ACS_IDX_ACTIVE, 8'h00);
    rd_chk(8'h10, 8'h00);
    prev = 8'h00;
    // Each refresh variant in turn, with every source code among the fields
    for (k = 0; k < 3; k++) begin
      xfer(1'b1, `ACS_IDX_PENDING, pend_val[k], rd);
      rd_chk(`ACS_IDX_PENDING, pend_exp[k]);
      rd_chk(`ACS_IDX_ACTIVE, prev);
      xfer(1'b1, `ACS_IDX_COMMAND, 8'h01 << k, rd);
      rd_chk(`ACS_IDX_STATUS, 8'h00);
      rd_chk(`ACS_IDX_LATCHED, prev);
      rd_chk(`ACS_IDX_ACTIVE, pend_exp[k]);
      chk({24'h0, ch1_sel, ch2_sel, ch3_sel, ch4_sel}, {24'h0, pend_exp[k]});
      for (i = 0; i < 40 && results_valid !== 1'b1; i++) begin
        @(posedge clk_sys);
      end
      rd_chk(`ACS_IDX_STATUS, 8'h01);
      rd_chk(`ACS_IDX_LATCHED, prev);
      prev = pend_exp[k];
    end
    // Reset in mid-run clears both images while they hold non-zero sources
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd_chk(`ACS_IDX_ACTIVE, `ACS_SEL_RESET);
    rd_chk(`ACS_IDX_LATCHED, `ACS_SEL_RESET);
    chk({24'h0, ch1_sel, ch2_sel, ch3_sel, ch4_sel}, 32'h0);
    rd_chk(`ACS_IDX_STATUS, 8'h00);
    report_and_stop;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    report_and_stop;
  end
endmodule // tb_accum_config_shadow_and_id_regs
`default_nettype wire
